// ==== adc_frame_pkg.sv ====
// Package with timing constants, phases and codes for the converter frame control.
package adc_frame_pkg;

	// Clock rate in kHz and period in ns.
	localparam int unsigned REF_CLK_KHZ = 20000;
	localparam int unsigned REF_CLK_NS = 50;

	// Sample word width and abort marker code.
	localparam int unsigned DATA_W = 14;
	localparam logic [13:0] ABORT_CODE = 14'h3f80;
	localparam logic [13:0] RESULT_RESET = 14'h0000;

	// Serial clock edge numbers that mark the frame phases.
	localparam logic [4:0] LAST_DATA_EDGE = 5'h0e;
	localparam logic [4:0] NAP_EXIT_EDGE = 5'h08;
	localparam logic [4:0] SAMPLE_EDGE = 5'h09;
	localparam logic [4:0] CONVERT_EDGE = 5'h10;

	// Initialisation conversions to discard.
	localparam logic [2:0] INIT_CONVERSIONS = 3'h4;

	// Conversion time and its cycle count, rounded down as a longest time.
	localparam int unsigned CONV_TIME_NS = 365;
	localparam int unsigned CONV_CYCLES_RAW = CONV_TIME_NS / REF_CLK_NS;
	localparam logic [3:0] CONV_CYCLES = 4'(CONV_CYCLES_RAW < 1 ? 1 : CONV_CYCLES_RAW);

	// Reset window maximum (ns) and power-down threshold (ns).
	localparam int unsigned RESET_WINDOW_TIME_NS = 6140;
	localparam int unsigned POWERDOWN_TIME_NS = 7200;
	localparam int unsigned RESET_WINDOW_CYCLES = RESET_WINDOW_TIME_NS / REF_CLK_NS;
	localparam int unsigned POWERDOWN_CYCLES = (POWERDOWN_TIME_NS + REF_CLK_NS - 1) / REF_CLK_NS;
	localparam logic [7:0] RESET_WINDOW_CNT = 8'(RESET_WINDOW_CYCLES);
	localparam logic [7:0] POWERDOWN_CNT = 8'(POWERDOWN_CYCLES);

	// Output release delay after the power-down pin falls.
	localparam int unsigned RESET_TO_OUTPUT_RELEASE_DELAY_NS = 10;

	// Sample abort delay after the ninth rising edge, in cycles (least time, rounded up).
	localparam int unsigned SAMPLE_ABORT_DELAY_NS = 5;
	localparam logic [1:0] SAMPLE_ABORT_CYCLES =
		2'((SAMPLE_ABORT_DELAY_NS + REF_CLK_NS - 1) / REF_CLK_NS);

	// Frame phases.
	typedef enum logic [4:0] {
		PH_IDLE = 5'b00001,
		PH_DATA = 5'b00010,
		PH_SAMPLE = 5'b00100,
		PH_CONVERT = 5'b01000,
		PH_POWER = 5'b10000
	} phase_e;

	// Result FIFO depth.
	localparam int unsigned FIFO_DEPTH = 16;

endpackage

// ==== adc_frame_abort_reset_ctrl.sv ====
// Frame sequencing, abort handling and power-down/reset control with a result FIFO.
`timescale 1ns/1ps


// =====================================================================
// Result FIFO
module adc_result_fifo #(
	parameter int unsigned WIDTH = 14,
	parameter int unsigned DEPTH = 16
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Fill side.
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side.
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// Full and empty come straight from the occupancy count.
	assign inReady = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign outData = mem[rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Storage writes.
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// Pointers and occupancy.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// =====================================================================
// Frame control
module adc_frame_abort_reset_ctrl (
	// Clock and logic reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Device power-down/reset pin, active low.
	input wire logic powerdown_reset_n,
	// Host serial interface pins.
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic frame_sync,
	output logic sdo,
	output logic sdoEn,
	output logic busy,
	// Conversion result source.
	input wire logic resultValid,
	output logic resultReady,
	input wire logic [13:0] resultData,
	// Status.
	output logic inResetPhase,
	output logic poweredDown,
	output logic napping,
	output logic initPending
);
	adc_frame_pkg::phase_e phase;
	logic sclkQ;
	logic csQ;
	logic fsQ;
	logic [4:0] riseCnt;
	logic [4:0] fallCnt;
	logic [13:0] shiftReg;
	logic [13:0] lastResult;
	logic abortFlag;
	logic [3:0] convCnt;
	logic [7:0] lowCnt;
	logic [2:0] initCnt;
	logic [1:0] sampleAge;
	logic sclkRise;
	logic sclkFall;
	logic csRise;
	logic csFall;
	logic fsRise;
	logic dspMode;
	logic frameStart;
	logic frameEndEdge;
	logic convDone;
	logic fifoOutValid;
	logic [13:0] fifoOutData;
	logic shiftOn;

	// Edge detection of the host pins, taken as synchronous inputs.
	// Every history bit resets to its pin's idle level, so no false edge appears after reset.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sclkQ <= 1'b1;
			csQ <= 1'b1;
			fsQ <= 1'b1;
		end else begin
			sclkQ <= sclk;
			csQ <= cs_n;
			fsQ <= frame_sync;
		end
	end

	assign sclkRise = sclk && !sclkQ;
	assign sclkFall = !sclk && sclkQ;
	assign csRise = cs_n && !csQ;
	assign csFall = !cs_n && csQ;
	assign fsRise = frame_sync && !fsQ;
	// Sync-serial mode is inferred whenever frame sync is low; four-wire keeps it high.
	assign dspMode = !frame_sync || fsRise;
	assign frameStart = dspMode ? (fsRise && !cs_n) : csFall;
	// Rising edge of chip select, or of frame sync in sync-serial mode, ends a frame early.
	assign frameEndEdge = csRise || (fsRise && phase != adc_frame_pkg::PH_CONVERT);
	assign convDone = (phase == adc_frame_pkg::PH_CONVERT) && (convCnt == adc_frame_pkg::CONV_CYCLES);

	// Result FIFO keeps completed conversions until a frame reads them.
	adc_result_fifo #(
		.WIDTH(adc_frame_pkg::DATA_W),
		.DEPTH(adc_frame_pkg::FIFO_DEPTH)
	) resultFifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.inValid(resultValid && convDone),
		.inReady(resultReady),
		.inData(resultData),
		.outValid(fifoOutValid),
		.outReady(frameStart && phase != adc_frame_pkg::PH_POWER),
		.outData(fifoOutData)
	);

	// Pin low time, used to tell a reset pulse from a power-down request.
	always_ff @(posedge ref_clk) begin
		if (!resetn || powerdown_reset_n) begin
			lowCnt <= '0;
		end else if (lowCnt != adc_frame_pkg::POWERDOWN_CNT) begin
			lowCnt <= lowCnt + 8'h01;
		end
	end

	assign inResetPhase = !powerdown_reset_n && (lowCnt <= adc_frame_pkg::RESET_WINDOW_CNT);
	assign poweredDown = !powerdown_reset_n && (lowCnt == adc_frame_pkg::POWERDOWN_CNT);

	// Frame phase sequencing.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			phase <= adc_frame_pkg::PH_IDLE;
		end else if (!powerdown_reset_n) begin
			phase <= adc_frame_pkg::PH_POWER;
		end else begin
			case (phase)
				adc_frame_pkg::PH_POWER: begin
					phase <= adc_frame_pkg::PH_IDLE;
				end
				adc_frame_pkg::PH_IDLE: begin
					if (frameStart) begin
						phase <= adc_frame_pkg::PH_DATA;
					end
				end
				adc_frame_pkg::PH_DATA: begin
					if (frameEndEdge) begin
						phase <= adc_frame_pkg::PH_IDLE;
					end else if (sclkRise && riseCnt + 5'h01 == adc_frame_pkg::SAMPLE_EDGE) begin
						phase <= adc_frame_pkg::PH_SAMPLE;
					end
				end
				adc_frame_pkg::PH_SAMPLE: begin
					if (frameEndEdge && sampleAge >= adc_frame_pkg::SAMPLE_ABORT_CYCLES) begin
						phase <= adc_frame_pkg::PH_CONVERT;
					end else if (sclkFall && fallCnt + 5'h01 == adc_frame_pkg::CONVERT_EDGE) begin
						phase <= adc_frame_pkg::PH_CONVERT;
					end
				end
				adc_frame_pkg::PH_CONVERT: begin
					if (frameStart) begin
						phase <= adc_frame_pkg::PH_DATA;
					end else if (convDone) begin
						phase <= adc_frame_pkg::PH_IDLE;
					end
				end
				default: begin
					phase <= adc_frame_pkg::PH_IDLE;
				end
			endcase
		end
	end

	// Serial clock edge counters, cleared at every frame start.
	always_ff @(posedge ref_clk) begin
		if (!resetn || frameStart) begin
			riseCnt <= '0;
			fallCnt <= '0;
		end else begin
			if (sclkRise && riseCnt != 5'h1f) begin
				riseCnt <= riseCnt + 5'h01;
			end
			if (sclkFall && fallCnt != 5'h1f) begin
				fallCnt <= fallCnt + 5'h01;
			end
		end
	end

	// Cycles since sampling began, so an edge too close to the 9th rise is not a sample abort.
	always_ff @(posedge ref_clk) begin
		if (!resetn || phase != adc_frame_pkg::PH_SAMPLE) begin
			sampleAge <= '0;
		end else if (sampleAge != 2'h3) begin
			sampleAge <= sampleAge + 2'h1;
		end
	end

	// Internal conversion timer; a counted conversion is the only source of busy.
	always_ff @(posedge ref_clk) begin
		if (!resetn || phase != adc_frame_pkg::PH_CONVERT) begin
			convCnt <= '0;
		end else if (convCnt != adc_frame_pkg::CONV_CYCLES) begin
			convCnt <= convCnt + 4'h1;
		end
	end

	// Busy while converting.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			busy <= 1'b0;
		end else begin
			busy <= powerdown_reset_n && phase == adc_frame_pkg::PH_CONVERT && !convDone && !frameStart;
		end
	end

	// Last good result and abort marker; an abort wins over a completion in the same cycle.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			lastResult <= adc_frame_pkg::RESULT_RESET;
			abortFlag <= 1'b0;
		end else begin
			// A frame that aborts a conversion shows the code itself, so only a power-down cut sets the flag.
			if (phase == adc_frame_pkg::PH_CONVERT && !powerdown_reset_n) begin
				abortFlag <= 1'b1;
			end else if (frameStart) begin
				abortFlag <= 1'b0;
			end
			if (frameStart && fifoOutValid) begin
				lastResult <= fifoOutData;
			end
		end
	end

	// Initialisation conversions counted after reset or power-up.
	always_ff @(posedge ref_clk) begin
		if (!resetn || !powerdown_reset_n) begin
			initCnt <= '0;
		end else if (convDone && initCnt != adc_frame_pkg::INIT_CONVERSIONS) begin
			initCnt <= initCnt + 3'h1;
		end
	end

	assign initPending = initCnt != adc_frame_pkg::INIT_CONVERSIONS;
	assign napping = phase == adc_frame_pkg::PH_IDLE ||
		(phase == adc_frame_pkg::PH_DATA && riseCnt < adc_frame_pkg::NAP_EXIT_EDGE);

	// Shift register: MSB at frame start, next bit on each rise up to the 14th.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			shiftReg <= '0;
			shiftOn <= 1'b0;
		end else if (!powerdown_reset_n) begin
			shiftOn <= 1'b0;
		end else if (frameStart) begin
			shiftOn <= 1'b1;
			if (abortFlag || phase == adc_frame_pkg::PH_CONVERT) begin
				shiftReg <= adc_frame_pkg::ABORT_CODE;
			end else begin
				shiftReg <= fifoOutValid ? fifoOutData : lastResult;
			end
		end else if (frameEndEdge) begin
			shiftOn <= 1'b0;
		end else if (sclkRise && shiftOn) begin
			shiftReg <= {shiftReg[12:0], 1'b0};
			if (riseCnt + 5'h01 >= adc_frame_pkg::LAST_DATA_EDGE) begin
				shiftOn <= 1'b0;
			end
		end
	end

	// Output pin drive; released whenever chip select is high or the device is held in reset.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sdo <= 1'b0;
			sdoEn <= 1'b0;
		end else begin
			sdo <= shiftReg[13];
			sdoEn <= powerdown_reset_n && !cs_n && shiftOn;
		end
	end
endmodule

// ==== adc_frame_properties.sv ====
// Timing properties of the converter frame control, bound to its top module.
`timescale 1ns/1ps
// ==========================================
// Checker
module adc_frame_properties (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic resetn,
	// Device pins.
	input wire logic powerdown_reset_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic frame_sync,
	input wire logic sdo,
	input wire logic sdoEn,
	input wire logic busy,
	// Result source.
	input wire logic resultValid,
	input wire logic resultReady,
	input wire logic [13:0] resultData,
	// Status.
	input wire logic inResetPhase,
	input wire logic poweredDown,
	input wire logic napping,
	input wire logic initPending
);
	logic [7:0] lowCnt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Length of the current low pulse on the pin; saturates so a long power-down never wraps.
	always_ff @(posedge ref_clk) begin
		if (!resetn || powerdown_reset_n) lowCnt <= 8'h00;
		else if (lowCnt != 8'hff) lowCnt <= lowCnt + 8'h01;
	end
	AST_PD_BUSY: assert property ($fell(powerdown_reset_n) |-> ##[1:2] !busy)
		else $error("busy kept through power-down");
	AST_PD_RELEASE: assert property ($fell(powerdown_reset_n) |-> ##[1:2] !sdoEn)
		else $error("serial output not released after power-down pin fell");
	AST_RESET_WINDOW: assert property ((lowCnt == 8'h32) |-> inResetPhase && !poweredDown)
		else $error("short pin pulse not in reset phase");
	AST_POWERED_DOWN: assert property ((lowCnt == 8'hc8) |-> poweredDown && !inResetPhase)
		else $error("long pin pulse did not power down");
	AST_INIT_AFTER: assert property ($rose(powerdown_reset_n) |-> ##[0:2] initPending)
		else $error("initialisation conversions not pending after reset");
	AST_CS_TRISTATE: assert property (cs_n [*3] |-> !sdoEn)
		else $error("serial output driven while chip select high");
	AST_CONV_BOUND: assert property ($rose(busy) |-> ##[1:7] !busy)
		else $error("conversion longer than its bound");
	AST_BUSY_MIN: assert property ($rose(busy) |-> busy [*3])
		else $error("busy dropped during conversion");
	AST_SPI_START: assert property ((frame_sync && $fell(cs_n) && powerdown_reset_n) ##1 !cs_n |-> ##[1:2] sdoEn)
		else $error("chip select fall did not present data");
	AST_DSP_START: assert property ((!cs_n && $rose(frame_sync) && powerdown_reset_n) ##1 !cs_n |-> ##[1:2] sdoEn)
		else $error("frame sync rise did not present data");
endmodule

bind adc_frame_abort_reset_ctrl adc_frame_properties u_props (.ref_clk, .resetn, .powerdown_reset_n, .sclk, .cs_n,
	.frame_sync, .sdo, .sdoEn, .busy, .resultValid, .resultReady, .resultData, .inResetPhase, .poweredDown,
	.napping, .initPending);

// ==== adc_host_model.sv ====
// Behavioural host serial port that frames, clocks and reads the converter.
`timescale 1ns/1ps
// ==========================================
// Host model
module adc_host_model (
	// Clock.
	input wire logic ref_clk,
	// Device serial pins.
	input wire logic sdo,
	input wire logic sdoEn,
	output logic sclk,
	output logic cs_n,
	output logic frame_sync
);
	logic lineLvl;
	// A released line shows the inverse bit, so a stale value never reads as good data.
	assign lineLvl = sdoEn ? sdo : ~sdo;
	// Serial clock stands high outside frames; four-wire mode at start.
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		frame_sync = 1'b1;
	end
	// Select the sync-serial mode (chip select held low) or the four-wire mode.
	task automatic set_mode(input logic dsp);
		@(posedge ref_clk);
		frame_sync <= !dsp;
		cs_n <= !dsp;
	endtask
	// Short chip-select pulse, used while a conversion runs and to cut a sync-serial frame.
	task automatic pulse_cs();
		@(posedge ref_clk);
		cs_n <= 1'b1;
		@(posedge ref_clk);
		cs_n <= 1'b0;
	endtask
	// One frame of nClk serial clocks; a four-wire frame ends by raising chip select.
	task automatic frame(input logic dsp, input int nClk, output logic [13:0] word);
		word = 14'h0000;
		@(posedge ref_clk);
		if (dsp) frame_sync <= 1'b1;
		else cs_n <= 1'b0;
		for (int i = 1; i <= nClk; i++) begin
			repeat (4) @(posedge ref_clk);
			if (dsp) frame_sync <= 1'b0;
			#1;
			if (i <= 14) word = {word[12:0], lineLvl};
			@(posedge ref_clk);
			sclk <= 1'b0;
			repeat (4) @(posedge ref_clk);
			sclk <= 1'b1;
		end
		@(posedge ref_clk);
		if (!dsp) cs_n <= 1'b1;
	endtask
endmodule

// ==== adc_frame_abort_reset_ctrl_test.sv ====
// Self-checking bench for the converter frame control and its result FIFO.
`timescale 1ns/1ps
// ==========================================
// Bench top
module adc_frame_abort_reset_ctrl_test;
	logic ref_clk, resetn, powerdown_reset_n, sclk, cs_n, frame_sync, sdo, sdoEn, busy;
	logic resultValid, resultReady, inResetPhase, poweredDown, napping, initPending;
	logic [13:0] resultData;
	int fail_count = 0;
	int num_checks = 0;
	adc_frame_abort_reset_ctrl u_dut (.ref_clk, .resetn, .powerdown_reset_n, .sclk, .cs_n, .frame_sync, .sdo, .sdoEn,
		.busy, .resultValid, .resultReady, .resultData, .inResetPhase, .poweredDown, .napping, .initPending);
	adc_host_model u_host (.ref_clk, .sdo, .sdoEn, .sclk, .cs_n, .frame_sync);
	// Clock at 20 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Compare a word and a flag.
	task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		check(what, {13'h0000, exp}, {13'h0000, got});
	endtask
	// Report and end the run.
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Wait for one conversion, bounded so a stuck busy line is reported.
	task automatic wait_conv();
		int n;
		n = 0;
		while (busy !== 1'b1 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		chk_bit("busy rose", 1'b1, busy);
		while (busy !== 1'b0 && n < 60) begin
			@(negedge ref_clk);
			n++;
		end
		chk_bit("busy fell", 1'b0, busy);
	endtask
	task automatic new_data(input logic [13:0] d);
		@(posedge ref_clk);
		resultData <= d;
	endtask
	// Four-wire frames back to back; each reads the result of the one before.
	task automatic t_spi_frames();
		logic [13:0] w;
		chk_bit("init pending", 1'b1, initPending);
		chk_bit("nap", 1'b1, napping);
		for (int k = 0; k < 5; k++) begin
			new_data(14'h0a50 + 14'(k));
			u_host.frame(1'b0, 16, w);
			wait_conv();
			if (k > 0) check("spi word", 14'h0a50 + 14'(k - 1), w);
		end
		chk_bit("init done", 1'b0, initPending);
	endtask
	// Abort before sampling, then during sampling.
	task automatic t_spi_abort();
		logic [13:0] w;
		new_data(14'h1111);
		u_host.frame(1'b0, 5, w);
		repeat (4) @(negedge ref_clk);
		chk_bit("released", 1'b0, sdoEn);
		chk_bit("no conversion", 1'b0, busy);
		u_host.frame(1'b0, 14, w);
		check("after early abort", 14'h0a54, w);
		wait_conv();
		u_host.frame(1'b0, 16, w);
		check("after sample abort", 14'h1111, w);
		new_data(14'h2222);
		u_host.frame(1'b0, 16, w);
		check("conv abort code", adc_frame_pkg::ABORT_CODE, w);
		wait_conv();
		u_host.frame(1'b0, 16, w);
		check("after conv abort", 14'h2222, w);
		wait_conv();
	endtask
	// Sync-serial frames, a chip-select pulse during conversion and a frame-sync abort.
	task automatic t_dsp();
		logic [13:0] w;
		u_host.set_mode(1'b1);
		new_data(14'h3333);
		u_host.frame(1'b1, 16, w);
		wait_conv();
		new_data(14'h3c3c);
		u_host.frame(1'b1, 16, w);
		check("dsp word", 14'h3333, w);
		u_host.pulse_cs();
		wait_conv();
		u_host.frame(1'b1, 16, w);
		check("cs ignored", 14'h3c3c, w);
		u_host.frame(1'b1, 16, w);
		check("dsp abort code", adc_frame_pkg::ABORT_CODE, w);
		wait_conv();
		// Chip-select abort before sampling, then a chip-select cut inside the sample phase.
		u_host.frame(1'b1, 5, w);
		u_host.pulse_cs();
		repeat (2) @(negedge ref_clk);
		chk_bit("dsp early abort", 1'b0, sdoEn);
		u_host.frame(1'b1, 16, w);
		check("dsp after early abort", 14'h3c3c, w);
		wait_conv();
		u_host.frame(1'b1, 12, w);
		u_host.pulse_cs();
		wait_conv();
	endtask
	// Long low pulse on the power-down pin, landing in a running conversion.
	task automatic t_power();
		logic [13:0] w;
		u_host.frame(1'b1, 16, w);
		@(posedge ref_clk);
		powerdown_reset_n <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk_bit("busy cut", 1'b0, busy);
		@(negedge ref_clk);
		chk_bit("reset phase", 1'b1, inResetPhase);
		chk_bit("sdo released", 1'b0, sdoEn);
		repeat (210) @(negedge ref_clk);
		chk_bit("powered down", 1'b1, poweredDown);
		@(posedge ref_clk);
		powerdown_reset_n <= 1'b1;
		repeat (3) @(negedge ref_clk);
		chk_bit("init again", 1'b1, initPending);
		u_host.frame(1'b1, 16, w);
		check("pd abort code", adc_frame_pkg::ABORT_CODE, w);
		wait_conv();
	endtask
	// Result FIFO through the top: each single queued word comes out on the next frame, an empty queue repeats the last word.
	task automatic t_fifo();
		logic [13:0] w;
		chk_bit("result ready", 1'b1, resultReady);
		new_data(14'h1e1e);
		u_host.frame(1'b1, 16, w);
		check("fifo pop", 14'h3c3c, w);
		wait_conv();
		@(posedge ref_clk);
		resultValid <= 1'b0;
		u_host.frame(1'b1, 16, w);
		check("fifo head", 14'h1e1e, w);
		wait_conv();
		chk_bit("ready when empty", 1'b1, resultReady);
		u_host.frame(1'b1, 16, w);
		check("fifo empty repeat", 14'h1e1e, w);
		wait_conv();
		@(posedge ref_clk);
		resultValid <= 1'b1;
	endtask
	// Main sequence.
	initial begin
		resetn = 1'b0;
		powerdown_reset_n = 1'b1;
		resultValid = 1'b0;
		resultData = 14'h0000;
		repeat (6) @(posedge ref_clk);
		resetn <= 1'b1;
		resultValid <= 1'b1;
		repeat (3) @(negedge ref_clk);
		t_spi_frames();
		t_spi_abort();
		t_dsp();
		t_power();
		t_fifo();
		give_verdict();
	end
	// Watchdog well beyond the few thousand cycles the tests take.
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		give_verdict();
	end
endmodule
